/* rtl/blz_unit.sv */
// byte load zero-extend execution unit, plain and base-update forms
// Notes on behaviour
// (RULE_01) opcode 34 is plain byte load; dest bits 6-10, base 11-15, disp 16-31.
// (RULE_02) opcode 35 is the update form, same field positions.
// (RULE_03) loaded byte lands in bits 24-31 of dest; bits 0-23 cleared.
// (RULE_04) nonzero base: address is base contents plus sign-extended 16-bit displacement.
// (RULE_05) base field zero: address is the displacement alone, register zero ignored.
// (RULE_06) update form writes address to base if base nonzero, not dest, no fault.
// (RULE_07) no exception register or condition field change; no record variant.
// (RULE_08) one byte read at the address; writeback waits for data or fault.
`timescale 1ns/1ps
module blz_unit
  import blz_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              issue_valid,
  input  wire logic [XLEN-1:0]   issue_instr,
  output logic                   issue_ready,
  output logic [RIDX_W-1:0]      base_rd_idx,
  input  wire logic [XLEN-1:0]   base_rd_data,
  output blz_mreq_t              mem_req,
  output logic [XLEN-1:0]        mem_byte_sel,
  input  wire logic              mem_rvalid,
  input  wire logic [BYTE_W-1:0] mem_rdata,
  input  wire logic              mem_align_fault,
  input  wire logic              mem_storage_fault,
  output blz_wr_t                dest_wr,
  output blz_wr_t                base_wr,
  output logic                   done,
  output logic                   fault,
  output logic                   illegal
);
  blz_dec_t              dec;
  logic [XLEN-1:0]       ea_comb;
  blz_state_t            state_q, state_d;
  blz_dec_t              ins_q, ins_d;
  blz_mreq_t             req_q, req_d;
  blz_wr_t               dwr_q, dwr_d, bwr_q, bwr_d;
  logic                  done_q, done_d, fault_q, fault_d, ill_q, ill_d;
  logic                  rdy_q, rdy_d;
  logic                  accept;

  // zero-extend one byte into a full register word
  function automatic logic [XLEN-1:0] zext_byte(input logic [BYTE_W-1:0] b);
    zext_byte = {{(XLEN-BYTE_W){1'b0}}, b};
  endfunction : zext_byte

  // base register is read combinationally from the issued word
  assign base_rd_idx = issue_instr[BASE_LSB +: RIDX_W];

  blz_decode u_dec (
    .instr            (issue_instr),
    .base_value       (base_rd_data),
    .dec              (dec),
    .computed_address (ea_comb)
  );

  assign accept = issue_valid && rdy_q;

  // next state and outputs
  always_comb begin
    state_d = state_q;
    ins_d   = ins_q;
    req_d   = req_q;
    dwr_d   = '0;
    bwr_d   = '0;
    done_d  = 1'b0;
    fault_d = 1'b0;
    ill_d   = 1'b0;
    rdy_d   = rdy_q;
    case (state_q)
      BLZ_IDLE: begin
        if (accept) begin
          if (dec.is_load) begin
            ins_d     = dec;
            req_d     = '{valid: 1'b1, addr: ea_comb};                 // RULE_08
            rdy_d     = 1'b0;
            state_d   = BLZ_REQ;
          end else begin
            ill_d     = 1'b1;                                          // unrecognised opcode
          end
        end
      end
      // an answer is taken in the request cycle as well as in wait, never dropped
      BLZ_REQ, BLZ_WAIT: begin
        req_d.valid = 1'b0;                                            // one-cycle request
        state_d     = BLZ_WAIT;
        if (mem_align_fault || mem_storage_fault) begin
          fault_d = 1'b1;                                              // RULE_08
          done_d  = 1'b1;
          rdy_d   = 1'b1;
          state_d = BLZ_IDLE;
        end else if (mem_rvalid) begin
          dwr_d = '{en: 1'b1, idx: ins_q.dest_reg_field, data: zext_byte(mem_rdata)}; // RULE_03
          if (ins_q.is_update && (ins_q.base_reg_field != REG_ZERO)
              && (ins_q.base_reg_field != ins_q.dest_reg_field)) begin
            bwr_d = '{en: 1'b1, idx: ins_q.base_reg_field, data: req_q.addr};         // RULE_06
          end
          done_d  = 1'b1;
          rdy_d   = 1'b1;
          state_d = BLZ_IDLE;
        end
      end
      default: begin
        state_d = BLZ_IDLE;
        rdy_d   = 1'b1;
      end
    endcase
  end

  // register stage; no exception or condition state is touched here
  always_ff @(posedge clk or posedge rst) begin // RULE_07
    if (rst) begin
      state_q <= BLZ_IDLE;
      ins_q   <= '0;
      req_q   <= '0;
      dwr_q   <= '0;
      bwr_q   <= '0;
      done_q  <= 1'b0;
      fault_q <= 1'b0;
      ill_q   <= 1'b0;
      rdy_q   <= 1'b1;
    end else begin
      state_q <= state_d;
      ins_q   <= ins_d;
      req_q   <= req_d;
      dwr_q   <= dwr_d;
      bwr_q   <= bwr_d;
      done_q  <= done_d;
      fault_q <= fault_d;
      ill_q   <= ill_d;
      rdy_q   <= rdy_d;
    end
  end

  // outputs straight from flops; the memory answer may come in the request
  // cycle or any later one and is taken when it comes
  assign issue_ready  = rdy_q;
  assign mem_req      = req_q;
  assign mem_byte_sel = req_q.addr;
  assign dest_wr      = dwr_q;
  assign base_wr      = bwr_q;
  assign done         = done_q;
  assign fault        = fault_q;
  assign illegal      = ill_q;

  // checks
  zext_upper_a: assert property (@(posedge clk) disable iff (rst)
    dest_wr.en |-> dest_wr.data[XLEN-1:BYTE_W] == '0)
    else $error("upper bits not cleared"); // RULE_03
  dest_byte_a: assert property (@(posedge clk) disable iff (rst)
    (state_q == BLZ_WAIT && mem_rvalid && !mem_align_fault && !mem_storage_fault)
      |=> dest_wr.en && dest_wr.data[BYTE_W-1:0] == $past(mem_rdata))
    else $error("loaded byte not written"); // RULE_03
  ea_base_a: assert property (@(posedge clk) disable iff (rst)
    (accept && dec.is_load && dec.base_reg_field != REG_ZERO)
      |=> mem_req.valid && mem_req.addr == $past(base_rd_data) + $past(dec.disp_ext))
    else $error("address sum wrong"); // RULE_04
  ea_zero_a: assert property (@(posedge clk) disable iff (rst)
    (accept && dec.is_load && dec.base_reg_field == REG_ZERO)
      |=> mem_req.addr == $past(dec.disp_ext))
    else $error("zero base not ignored"); // RULE_05
  sign_ext_a: assert property (@(posedge clk) disable iff (rst)
    dec.disp_ext[XLEN-1:DISP_W] == {(XLEN-DISP_W){issue_instr[DISP_LSB+DISP_W-1]}})
    else $error("displacement not sign-extended"); // RULE_04
  opc_match_a: assert property (@(posedge clk) disable iff (rst)
    (accept && issue_instr[OPC_LSB +: 6] != OPC_PLAIN && issue_instr[OPC_LSB +: 6] != OPC_UPDATE)
      |=> illegal && !mem_req.valid)
    else $error("foreign opcode accepted"); // RULE_01
  upd_guard_a: assert property (@(posedge clk) disable iff (rst)
    base_wr.en |-> ins_q.is_update && base_wr.idx != REG_ZERO
      && base_wr.idx != dest_wr.idx && !$past(mem_align_fault) && !$past(mem_storage_fault))
    else $error("illegal base update"); // RULE_06
  upd_value_a: assert property (@(posedge clk) disable iff (rst)
    base_wr.en |-> base_wr.data == req_q.addr && dest_wr.en)
    else $error("base update value wrong"); // RULE_06
  wb_hold_a: assert property (@(posedge clk) disable iff (rst)
    (mem_req.valid ##1 (!mem_rvalid && !mem_align_fault && !mem_storage_fault)[*2])
      |-> !dest_wr.en)
    else $error("writeback before data"); // RULE_08
  req_pulse_a: assert property (@(posedge clk) disable iff (rst)
    mem_req.valid |=> !mem_req.valid ##1 !mem_req.valid)
    else $error("request not single"); // RULE_08
  plain_cv: cover property (@(posedge clk) disable iff (rst) dest_wr.en && !ins_q.is_update);
  upd_cv: cover property (@(posedge clk) disable iff (rst) base_wr.en);
  fault_cv: cover property (@(posedge clk) disable iff (rst) fault);
  upd_same_cv: cover property (@(posedge clk) disable iff (rst)
    dest_wr.en && ins_q.is_update && !base_wr.en);
endmodule : blz_unit

/* include/blz_pkg.sv */
// shared constants and carrier types for the byte load zero-extend unit
package blz_pkg;
  localparam int unsigned XLEN         = 32;
  localparam int unsigned RIDX_W       = 5;
  localparam logic [5:0]  OPC_PLAIN    = 6'h22;  // primary opcode 34
  localparam logic [5:0]  OPC_UPDATE   = 6'h23;  // primary opcode 35
  // instruction field positions, big-endian bit 0 is msb, so lsb index = 31 - end bit
  localparam int unsigned OPC_LSB      = 26;     // bits 0-5
  localparam int unsigned DEST_LSB     = 21;     // bits 6-10
  localparam int unsigned BASE_LSB     = 16;     // bits 11-15
  localparam int unsigned DISP_LSB     = 0;      // bits 16-31
  localparam int unsigned DISP_W       = 16;
  localparam int unsigned BYTE_W       = 8;
  localparam logic [RIDX_W-1:0] REG_ZERO = 5'h00;
  localparam logic [XLEN-1:0]   WORD_ZERO = 32'h0000_0000;

  typedef enum logic [1:0] {
    BLZ_IDLE = 2'b00,
    BLZ_REQ  = 2'b01,
    BLZ_WAIT = 2'b11,
    BLZ_DONE = 2'b10
  } blz_state_t;

  // decoded instruction
  typedef struct packed {
    logic              is_load;
    logic              is_update;
    logic [RIDX_W-1:0] dest_reg_field;
    logic [RIDX_W-1:0] base_reg_field;
    logic [XLEN-1:0]   disp_ext;
  } blz_dec_t;

  // register file write port
  typedef struct packed {
    logic              en;
    logic [RIDX_W-1:0] idx;
    logic [XLEN-1:0]   data;
  } blz_wr_t;

  // memory read request
  typedef struct packed {
    logic            valid;
    logic [XLEN-1:0] addr;
  } blz_mreq_t;
endpackage : blz_pkg

/* rtl/blz_decode.sv */
// instruction field decoder and effective address former
`timescale 1ns/1ps
module blz_decode
  import blz_pkg::*;
(
  input  wire logic [XLEN-1:0] instr,
  input  wire logic [XLEN-1:0] base_value,
  output blz_dec_t             dec,
  output logic     [XLEN-1:0]  computed_address
);
  logic [5:0] opc;

  // field extraction and opcode match
  always_comb begin
    opc                = instr[OPC_LSB +: 6];
    dec.is_update      = (opc == OPC_UPDATE);                          // RULE_02
    dec.is_load        = (opc == OPC_PLAIN) || dec.is_update;          // RULE_01
    dec.dest_reg_field = instr[DEST_LSB +: RIDX_W];                    // RULE_01
    dec.base_reg_field = instr[BASE_LSB +: RIDX_W];                    // RULE_01
    dec.disp_ext = {{(XLEN-DISP_W){instr[DISP_LSB+DISP_W-1]}}, instr[DISP_LSB +: DISP_W]}; // RULE_04
  end

  // base of zero means displacement alone
  always_comb begin
    if (dec.base_reg_field == REG_ZERO) begin
      computed_address = dec.disp_ext;                                 // RULE_05
    end else begin
      computed_address = base_value + dec.disp_ext;                    // RULE_04
    end
  end
endmodule : blz_decode

/* bench/blz_mem_model.sv */
// register file and data memory model facing the unit
`timescale 1ns/1ps
module blz_mem_model
  import blz_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic [RIDX_W-1:0] base_rd_idx,
  output logic      [XLEN-1:0]   base_rd_data,
  input  wire blz_mreq_t         mem_req,
  input  wire logic [3:0]        lat,
  input  wire logic [1:0]        flt,
  output logic                   mem_rvalid,
  output logic      [BYTE_W-1:0] mem_rdata,
  output logic                   mem_align_fault,
  output logic                   mem_storage_fault
);
  logic [3:0]      cnt_q;
  logic [XLEN-1:0] addr_q;
  logic            ans;
  logic [7:0]      byt;
  // register contents, register zero nonzero so ignoring it is visible
  assign base_rd_data = {8'h5A, 3'h0, base_rd_idx, 16'h8000};
  // countdown to the answer after each byte read request
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q  <= 4'h0;
      addr_q <= 32'h0000_0000;
    end else if (mem_req.valid) begin
      cnt_q  <= lat;
      addr_q <= mem_req.addr;
    end else if (cnt_q != 4'h0) begin
      cnt_q <= cnt_q - 4'h1;
    end
  end
  // one-cycle answer, data line inverted when not answering
  assign ans               = (cnt_q == 4'h1);
  assign byt               = addr_q[7:0] ^ addr_q[15:8];
  assign mem_rdata         = ans ? byt : ~byt;
  assign mem_rvalid        = ans && (flt == 2'b00);
  assign mem_align_fault   = ans && flt[0];
  assign mem_storage_fault = ans && flt[1];
endmodule : blz_mem_model

/* bench/blz_unit_tb.sv */
// self-checking bench for the byte load zero-extend unit
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_errors++; \
  $display("unexpected t=%0t got=%h exp=%h", $time, (a), (b)); end end
module blz_unit_tb;
  import blz_pkg::*;
  logic              clk = 1'b0, rst = 1'b1, issue_valid = 1'b0, issue_ready;
  logic [XLEN-1:0]   issue_instr = 32'h0000_0000, base_rd_data, mem_byte_sel;
  logic [RIDX_W-1:0] base_rd_idx;
  logic [BYTE_W-1:0] mem_rdata;
  logic              mem_rvalid, mem_align_fault, mem_storage_fault;
  logic              done, fault, illegal;
  logic [3:0]        lat = 4'h1;
  logic [1:0]        flt = 2'b00;
  blz_mreq_t         mem_req;
  blz_wr_t           dest_wr, base_wr;
  int                n_errors = 0, cmp_count = 0;
  // free-running 100 MHz clock
  always #5 clk = ~clk;
  blz_unit dut (.clk(clk), .rst(rst), .issue_valid(issue_valid),
    .issue_instr(issue_instr), .issue_ready(issue_ready), .base_rd_idx(base_rd_idx),
    .base_rd_data(base_rd_data), .mem_req(mem_req), .mem_byte_sel(mem_byte_sel),
    .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata), .mem_align_fault(mem_align_fault),
    .mem_storage_fault(mem_storage_fault), .dest_wr(dest_wr), .base_wr(base_wr),
    .done(done), .fault(fault), .illegal(illegal));
  blz_mem_model mem (.clk(clk), .rst(rst), .base_rd_idx(base_rd_idx),
    .base_rd_data(base_rd_data), .mem_req(mem_req), .lat(lat), .flt(flt),
    .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata), .mem_align_fault(mem_align_fault),
    .mem_storage_fault(mem_storage_fault));
  // print counts and verdict, end the run
  task automatic stop_test;
    $display("errors=%0d compares=%0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : stop_test
  // one load with memory latency l and fault mode f, judged at done
  task automatic do_load(input logic [5:0] op, input logic [4:0] d, input logic [4:0] b,
                         input logic [15:0] disp, input logic [3:0] l, input logic [1:0] f);
    logic [31:0] ea;
    logic        upd;
    int          i;
    ea  = {{16{disp[15]}}, disp} + ((b == 5'h00) ? 32'h0 : {8'h5A, 3'h0, b, 16'h8000});
    upd = (op == 6'h23) && (b != 5'h00) && (b != d) && (f == 2'b00);
    @(negedge clk);
    lat         = l;
    flt         = f;
    issue_valid = 1'b1;
    issue_instr = {op, d, b, disp};
    @(negedge clk);
    issue_valid = 1'b0;
    `CHK(mem_req.valid, 1'b1)
    `CHK(mem_req.addr, ea)
    `CHK(mem_byte_sel, ea)
    `CHK(issue_ready, 1'b0)
    for (i = 0; i < 20 && done !== 1'b1; i++) @(negedge clk);
    if (done !== 1'b1) begin
      n_errors++;
      stop_test();
    end
    `CHK(i, int'(l) + 1)
    `CHK(fault, f != 2'b00)
    `CHK(dest_wr.en, f == 2'b00)
    if (f == 2'b00) `CHK(dest_wr.idx, d)
    if (f == 2'b00) `CHK(dest_wr.data, {24'h0, ea[7:0] ^ ea[15:8]})
    `CHK(base_wr.en, upd)
    if (upd) `CHK(base_wr.data, ea)
    if (upd) `CHK(base_wr.idx, b)
  endtask : do_load
  // scenarios
  task automatic s_plain;
    do_load(6'h22, 5'h03, 5'h07, 16'h0010, 4'h1, 2'b00);
  endtask : s_plain
  task automatic s_base_zero;
    do_load(6'h22, 5'h05, 5'h00, 16'hFFF0, 4'h2, 2'b00);
  endtask : s_base_zero
  task automatic s_update;
    do_load(6'h23, 5'h04, 5'h09, 16'h8000, 4'h3, 2'b00);
  endtask : s_update
  task automatic s_update_skip;
    do_load(6'h23, 5'h06, 5'h06, 16'h0001, 4'h1, 2'b00);
    do_load(6'h23, 5'h06, 5'h00, 16'h7FFF, 4'h1, 2'b00);
  endtask : s_update_skip
  task automatic s_fault;
    do_load(6'h23, 5'h02, 5'h0A, 16'h0004, 4'h2, 2'b01);
    do_load(6'h23, 5'h02, 5'h0A, 16'h0004, 4'h1, 2'b10);
  endtask : s_fault
  task automatic s_illegal;
    @(negedge clk);
    issue_valid = 1'b1;
    issue_instr = {6'h24, 26'h0210008};
    @(negedge clk);
    issue_valid = 1'b0;
    `CHK(illegal, 1'b1)
    `CHK(mem_req.valid, 1'b0)
    `CHK(issue_ready, 1'b1)
  endtask : s_illegal
  // reset, then the scenarios
  initial begin
    repeat (8) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    s_plain();
    s_base_zero();
    s_update();
    s_update_skip();
    s_fault();
    s_illegal();
    s_plain();
    stop_test();
  end
endmodule : blz_unit_tb
